// ---- logic/region_prot.sv ----
`timescale 1ns/1ps
// protection unit: register port plus per-access region check
module region_prot #(
    parameter int          REGIONS = 8,
    parameter logic [7:0]  DATA_REGIONS = 8'h08
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        reg_sel,
    input  wire logic        reg_write,
    input  wire logic [31:0] reg_addr,
    input  wire logic [1:0]  reg_size,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_write,
    input  wire logic        acc_fetch,
    input  wire logic        acc_priv,
    input  wire logic        acc_dma,
    output logic             acc_done,
    output logic             acc_fault
);
    localparam int IW = $clog2(REGIONS);

    logic [7:0]          select_ff;
    logic [31:0]         control_ff;
    logic [7:0]          ofs;
    logic                is_base;
    logic                is_attr;
    logic [7:0]          rd_word_ofs;
    logic [IW-1:0]       wr_idx;
    logic [3:0]          wr_be;
    logic [31:0]         rd_base;
    logic [31:0]         rd_attr;
    logic [REGIONS*32-1:0] all_base;
    logic [REGIONS*32-1:0] all_attr;
    logic                rd_pend_ff;
    logic [7:0]          rd_ofs_ff;
    logic                hit_any;
    logic                hit_perm;

    // byte lanes of a write; unaligned halfword and word writes fall back to their aligned lanes
    function automatic logic [3:0] lanes(input logic [1:0] sz,
                                         input logic [1:0] a);
        logic [3:0] r;
        r = 4'h0;
        case (sz)
            2'd0:    r = 4'h1 << a;
            2'd1:    r = a[1] ? 4'hC : 4'h3;
            default: r = 4'hF;
        endcase
        return r;
    endfunction

    // access permission: write, privilege and ap field
    function automatic logic ap_ok(input logic [2:0] ap,
                                   input logic pr, input logic wr);
        logic r;
        r = 1'b0;
        case (ap)
            3'd1:    r = pr;
            3'd2:    r = pr | ~wr;
            3'd3:    r = 1'b1;
            3'd5:    r = pr & ~wr;
            3'd6,
            3'd7:    r = ~wr;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign ofs = reg_addr[7:0] - region_prot_pkg::UNIT_BASE[7:0];
    assign is_base = (ofs == region_prot_pkg::OFS_BASE)
                   | (ofs == region_prot_pkg::OFS_BASE_A1)
                   | (ofs == region_prot_pkg::OFS_BASE_A2)
                   | (ofs == region_prot_pkg::OFS_BASE_A3);
    assign is_attr = (ofs[7:2] == region_prot_pkg::OFS_ATTR[7:2])
                   | (ofs[7:2] == region_prot_pkg::OFS_ATTR_A1[7:2])
                   | (ofs[7:2] == region_prot_pkg::OFS_ATTR_A2[7:2])
                   | (ofs[7:2] == region_prot_pkg::OFS_ATTR_A3[7:2]);
    // aliases use the selected region; a base write with valid uses the region in its data
    assign wr_idx = (is_base && reg_wdata[region_prot_pkg::BASE_VALID_BIT])
                  ? reg_wdata[IW-1:0] : select_ff[IW-1:0];
    assign wr_be = lanes(reg_size, reg_addr[1:0]);

    region_table #(.REGIONS(REGIONS)) u_table (
        .clk      (clk),
        .reset    (reset),
        .wr_base  (reg_sel & reg_write & is_base),
        .wr_attr  (reg_sel & reg_write & is_attr),
        .wr_idx   (wr_idx),
        .wr_data  (reg_wdata),
        .wr_be    (wr_be),
        .rd_idx   (select_ff[IW-1:0]),
        .rd_base  (rd_base),
        .rd_attr  (rd_attr),
        .all_base (all_base),
        .all_attr (all_attr)
    );

    // region select register; base write with valid updates it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            select_ff <= region_prot_pkg::ZERO_RST[7:0];
        end else if (reg_sel && reg_write) begin
            // select at 0x98; base and attr words follow at +4, +8
            if (ofs == region_prot_pkg::OFS_SELECT) begin
                select_ff <= reg_wdata[7:0];
            end else if (is_base
                         && reg_wdata[region_prot_pkg::BASE_VALID_BIT]) begin
                select_ff <= {4'h0, reg_wdata[3:0]};
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            control_ff <= region_prot_pkg::CONTROL_RST;
        end else if (reg_sel && reg_write
                     && ofs == region_prot_pkg::OFS_CONTROL) begin
            control_ff <= reg_wdata & region_prot_pkg::CONTROL_MASK;
        end
    end
    // capability writes fall through untouched
    // control bit 0 turns checking on, bit 2 lets privileged misses pass

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_pend_ff <= 1'b0;
            rd_ofs_ff  <= 8'h00;
        end else begin
            rd_pend_ff <= reg_sel & ~reg_write;
            rd_ofs_ff  <= ofs;
        end
    end

    assign reg_rvalid = rd_pend_ff;
    // narrow reads of a register see its whole word
    assign rd_word_ofs = {rd_ofs_ff[7:2], 2'b00};
    // answer stands one cycle; the data lines rest at zero otherwise
    always_comb begin
        reg_rdata = region_prot_pkg::ZERO_RST;
        if (rd_pend_ff) begin
            case (rd_word_ofs)
                region_prot_pkg::OFS_CAPABILITY:
                    reg_rdata = {8'h00, 8'h00, DATA_REGIONS,
                                 7'h00, 1'b0};
                region_prot_pkg::OFS_CONTROL: reg_rdata = control_ff;
                region_prot_pkg::OFS_SELECT:  reg_rdata = {24'h0, select_ff};
                region_prot_pkg::OFS_BASE,
                region_prot_pkg::OFS_BASE_A1,
                region_prot_pkg::OFS_BASE_A2,
                region_prot_pkg::OFS_BASE_A3:
                    reg_rdata = {rd_base[31:5], 1'b0, select_ff[3:0]};
                region_prot_pkg::OFS_ATTR,
                region_prot_pkg::OFS_ATTR_A1,
                region_prot_pkg::OFS_ATTR_A2,
                region_prot_pkg::OFS_ATTR_A3:
                    reg_rdata = rd_attr;
                default: reg_rdata = region_prot_pkg::ZERO_RST;
            endcase
        end
    end

    // region match: highest enabled region with live subregion wins
    always_comb begin
        logic [31:0] b;
        logic [31:0] a;
        logic [4:0]  sz;
        logic [32:0] span;
        logic [32:0] off;
        logic [2:0]  sub;
        hit_any  = 1'b0;
        hit_perm = 1'b0;
        b = 32'h0;
        a = 32'h0;
        sz = 5'h0;
        span = 33'h0;
        off = 33'h0;
        sub = 3'h0;
        for (int i = 0; i < REGIONS; i++) begin
            b = all_base[i*32 +: 32];
            a = all_attr[i*32 +: 32];
            sz = a[region_prot_pkg::SIZE_LSB +: 5];
            // size 31 is the whole 4 GB map: widen before adding one
            span = 33'h1 << ({1'b0, sz} + 6'd1);
            off = {1'b0, acc_addr} - {1'b0, b & ~(span[31:0] - 32'h1)};
            sub = 3'(off >> (sz - 5'd2));
            if (a[region_prot_pkg::EN_BIT] && off < span
                && !(sz >= region_prot_pkg::SIZE_MIN_SUB
                     && a[region_prot_pkg::SUBDIS_LSB + sub])) begin
                // disable bits from 15:8, enable from bit 0
                hit_any  = 1'b1;
                hit_perm = ap_ok(a[region_prot_pkg::AP_LSB +: 3],
                                 acc_priv, acc_write)
                         & ~(acc_fetch & a[region_prot_pkg::XN_BIT]);
                // cache and share bits not consulted
            end
        end
    end

    // registered check; register writes land before next access
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_done  <= 1'b0;
            acc_fault <= 1'b0;
        end else begin
            acc_done <= acc_valid;
            if (!acc_valid || acc_dma || !control_ff[0]) begin
                acc_fault <= 1'b0;
            end else if (hit_any) begin
                acc_fault <= ~hit_perm;
            end else begin
                // no hit: only with control bit 2 set does the background map serve privileged accesses; all others fault
                acc_fault <= ~(control_ff[2] & acc_priv);
            end
        end
    end
endmodule

// ---- logic/region_prot_pkg.sv ----
package region_prot_pkg;
    localparam logic [31:0] UNIT_BASE      = 32'hE000_ED90;
    localparam logic [7:0]  OFS_CAPABILITY = 8'h00;
    localparam logic [7:0]  OFS_CONTROL    = 8'h04;
    localparam logic [7:0]  OFS_SELECT     = 8'h08;
    localparam logic [7:0]  OFS_BASE       = 8'h0C;
    localparam logic [7:0]  OFS_ATTR       = 8'h10;
    localparam logic [7:0]  OFS_BASE_A1    = 8'h14;
    localparam logic [7:0]  OFS_ATTR_A1    = 8'h18;
    localparam logic [7:0]  OFS_BASE_A2    = 8'h1C;
    localparam logic [7:0]  OFS_ATTR_A2    = 8'h20;
    localparam logic [7:0]  OFS_BASE_A3    = 8'h24;
    localparam logic [7:0]  OFS_ATTR_A3    = 8'h28;
    localparam logic [31:0] CAPABILITY_RST = 32'h0000_0800;
    localparam logic [31:0] CONTROL_RST    = 32'h0000_0000;
    localparam logic [31:0] ZERO_RST       = 32'h0000_0000;
    localparam int          BASE_VALID_BIT = 4;
    localparam int          SUBDIS_LSB     = 8;
    localparam int          SIZE_LSB       = 1;
    localparam int          EN_BIT         = 0;
    localparam int          XN_BIT         = 28;
    localparam int          AP_LSB         = 24;
    localparam logic [4:0]  SIZE_MIN_SUB   = 5'h07;
    localparam logic [31:0] BASE_MASK      = 32'hFFFF_FFE0;
    localparam logic [31:0] ATTR_MASK      = 32'h173F_FF3F;
    localparam logic [31:0] CONTROL_MASK   = 32'h0000_0007;
endpackage

// ---- logic/region_table.sv ----
`timescale 1ns/1ps
// per-region base and attribute storage, registered read port
module region_table #(
    parameter int REGIONS = 8
) (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       wr_base,
    input  wire logic                       wr_attr,
    input  wire logic [$clog2(REGIONS)-1:0] wr_idx,
    input  wire logic [31:0]                wr_data,
    input  wire logic [3:0]                 wr_be,
    input  wire logic [$clog2(REGIONS)-1:0] rd_idx,
    output logic      [31:0]                rd_base,
    output logic      [31:0]                rd_attr,
    output logic      [REGIONS*32-1:0]      all_base,
    output logic      [REGIONS*32-1:0]      all_attr
);
    logic [31:0] base_ff [REGIONS];
    logic [31:0] attr_ff [REGIONS];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < REGIONS; i++) begin
                base_ff[i] <= region_prot_pkg::ZERO_RST;
                attr_ff[i] <= region_prot_pkg::ZERO_RST;
            end
        end else begin
            if (wr_base) begin
                base_ff[wr_idx] <= wr_data & region_prot_pkg::BASE_MASK;
            end
            if (wr_attr) begin
                for (int b = 0; b < 4; b++) begin
                    if (wr_be[b]) begin
                        attr_ff[wr_idx][b*8 +: 8] <= wr_data[b*8 +: 8]
                            & region_prot_pkg::ATTR_MASK[b*8 +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_base <= region_prot_pkg::ZERO_RST;
            rd_attr <= region_prot_pkg::ZERO_RST;
        end else begin
            rd_base <= base_ff[rd_idx];
            rd_attr <= attr_ff[rd_idx];
        end
    end

    always_comb begin
        for (int i = 0; i < REGIONS; i++) begin
            all_base[i*32 +: 32] = base_ff[i];
            all_attr[i*32 +: 32] = attr_ff[i];
        end
    end
endmodule

// ---- test/core_model.sv ----
`timescale 1ns/1ps
module core_model (
    input  wire logic        clk,
    output logic             reg_sel,
    output logic             reg_write,
    output logic [31:0]      reg_addr,
    output logic [1:0]       reg_size,
    output logic [31:0]      reg_wdata,
    output logic             acc_valid,
    output logic [31:0]      acc_addr,
    output logic             acc_write,
    output logic             acc_fetch,
    output logic             acc_priv,
    output logic             acc_dma
);
    initial begin
        {reg_sel, reg_write, reg_addr, reg_size, reg_wdata} = '0;
        {acc_valid, acc_addr, acc_write, acc_fetch, acc_priv} = '0;
        acc_dma = 1'b0;
    end
    // one register access at a time, in program order, never interleaved
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [1:0] s, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_sel = 1'b1;
        reg_write = w;
        reg_addr = a;
        reg_size = s;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_sel = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // accesses start only once earlier register writes have landed,
    // as after a barrier
    task automatic mem(input logic [31:0] a, input logic p, input logic dma,
                       input logic w);
        @(posedge clk);
        #1;
        {acc_valid, acc_addr, acc_priv, acc_dma} = {1'b1, a, p, dma};
        acc_write = w;
        @(posedge clk);
        #1;
        acc_valid = 1'b0;
        acc_addr = ~a;
    endtask
endmodule

// ---- test/region_prot_bench.sv ----
`timescale 1ns/1ps
module region_prot_bench;
    localparam logic [31:0] B = region_prot_pkg::UNIT_BASE;
    logic        clk;
    logic        reset;
    logic        reg_sel, reg_write, reg_rvalid, acc_valid, acc_write;
    logic        acc_fetch, acc_priv, acc_dma, acc_done, acc_fault;
    logic [1:0]  reg_size;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, acc_addr;
    int          num_errors = 0;
    int          check_count = 0;
    logic [31:0] exp_q[$];
    string       name_q[$];
    logic [31:0] fault_word;
    assign fault_word = {31'h0, acc_fault};

    always #4 clk = ~clk;
    region_prot dut_u (.clk(clk), .reset(reset), .reg_sel(reg_sel),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_size(reg_size),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
        .acc_fetch(acc_fetch), .acc_priv(acc_priv), .acc_dma(acc_dma),
        .acc_done(acc_done), .acc_fault(acc_fault));
    core_model core_u (.clk(clk), .reg_sel(reg_sel), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
        .acc_fetch(acc_fetch), .acc_priv(acc_priv), .acc_dma(acc_dma));

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic expect_rd(string n, logic [31:0] a, logic [31:0] v);
        name_q.push_back(n);
        exp_q.push_back(v);
        core_u.bus(1'b0, a, 2'd2, 32'h0000_0000);
    endtask
    task automatic expect_acc(string n, logic [31:0] a, logic d, logic f);
        expect_acc_as(n, a, d, f, 1'b0, 1'b0);
    endtask
    task automatic expect_acc_as(string n, logic [31:0] a, logic d,
                                 logic f, logic p, logic w);
        name_q.push_back(n);
        exp_q.push_back({31'h0, f});
        core_u.mem(a, p, d, w);
    endtask
    task automatic wrap_up();
        if (exp_q.size() != 0) num_errors++;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
        end
        if (acc_done === 1'b1) begin
            check(name_q.pop_front(), fault_word, exp_q.pop_front());
        end
    end

    initial begin
        repeat (3000) @(posedge clk);
        $display("watchdog expired");
        num_errors++;
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        void'($urandom(32'h78d4_f925));
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        expect_rd("capability", B, 32'h0000_0800);
        core_u.bus(1'b1, B, 2'd2, $urandom());
        expect_rd("capability after write", B, 32'h0000_0800);
        $display("test capability done");
        core_u.bus(1'b1, B + 32'h8, 2'd2, 32'h0000_0001);
        core_u.bus(1'b1, B + 32'hC, 2'd2, 32'h2000_0007);
        expect_rd("select", B + 32'h8, 32'h0000_0001);
        expect_rd("base", B + 32'hC, 32'h2000_0001);
        core_u.bus(1'b1, B + 32'h10, 2'd1, 32'h0000_0212);
        core_u.bus(1'b1, B + 32'h12, 2'd1, 32'h0302_0000);
        core_u.bus(1'b1, B + 32'h10, 2'd1, 32'h0000_0213);
        expect_rd("attr", B + 32'h10, 32'h0302_0213);
        expect_rd("unmapped", B + 32'h30, 32'h0000_0000);
        $display("test registers done");
        expect_acc("unit off", 32'h2000_0080, 1'b0, 1'b0);
        core_u.bus(1'b1, B + 32'h4, 2'd2, 32'h0000_0001);
        for (int i = 0; i < 9; i++) begin
            expect_acc("subregion",
                       32'h2000_0000 + i * 128 + ($urandom() % 128),
                       1'b0, i == 1 || i == 8);
        end
        expect_acc("dma", 32'h2000_0080, 1'b1, 1'b0);
        $display("test subregions done");
        core_u.bus(1'b1, B + 32'h14, 2'd2, 32'h2000_0014);
        core_u.bus(1'b1, B + 32'h18, 2'd2, 32'h0302_0017);
        expect_rd("select by alias", B + 32'h8, 32'h0000_0004);
        expect_acc("overlap", 32'h2000_0080, 1'b0, 1'b0);
        core_u.bus(1'b1, B + 32'h1C, 2'd2, 32'h3000_0012);
        core_u.bus(1'b1, B + 32'h20, 2'd2, 32'h0600_000D);
        expect_acc("read only read", 32'h3000_0040, 1'b0, 1'b0);
        expect_acc_as("read only write", 32'h3000_0040, 1'b0, 1'b1,
                      1'b0, 1'b1);
        expect_acc("no region", 32'h3000_0080, 1'b0, 1'b1);
        $display("test alias done");
        core_u.bus(1'b1, B + 32'h4, 2'd2, 32'h0000_0005);
        expect_rd("control", B + 32'h4, 32'h0000_0005);
        expect_acc_as("background priv", 32'h3000_0080, 1'b0, 1'b0,
                      1'b1, 1'b0);
        expect_acc("background user", 32'h3000_0080, 1'b0, 1'b1);
        core_u.bus(1'b1, B + 32'h8, 2'd2, 32'h0000_0004);
        core_u.bus(1'b1, B + 32'h10, 2'd0, 32'h0000_0016);
        expect_rd("attr byte", B + 32'h10, 32'h0302_0016);
        expect_acc("region dropped", 32'h2000_0080, 1'b0, 1'b1);
        $display("test reconfigure done");
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule

// ---- test/region_prot_properties.sv ----
`timescale 1ns/1ps
module region_prot_properties (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        reg_sel,
    input  wire logic        reg_write,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid,
    input  wire logic        acc_valid,
    input  wire logic        acc_dma,
    input  wire logic        acc_done,
    input  wire logic        acc_fault
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    chk_read_answer: assert property (
        reg_sel && !reg_write |=> reg_rvalid) else $error("read lost");
    chk_rvalid_cause: assert property (
        reg_rvalid |-> $past(reg_sel) && !$past(reg_write))
        else $error("read answer without request");
    chk_cap_value: assert property (
        reg_sel && !reg_write && reg_addr == region_prot_pkg::UNIT_BASE
        |=> reg_rdata == 32'h0000_0800) else $error("capability value");
    chk_base_valid_zero: assert property (
        reg_sel && !reg_write && reg_addr == 32'hE000_ED9C
        |=> !reg_rdata[4]) else $error("base valid bit read as one");
    chk_rdata_quiet: assert property (
        !reg_rvalid |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside answer");
    chk_done_follows: assert property (
        acc_valid |=> acc_done) else $error("check not answered");
    chk_done_cause: assert property (
        acc_done |-> $past(acc_valid)) else $error("answer without check");
    chk_dma_bypass: assert property (
        acc_valid && acc_dma |=> !acc_fault) else $error("dma faulted");
    chk_fault_pairs: assert property (
        acc_fault |-> acc_done) else $error("fault without done");
endmodule
bind region_prot region_prot_properties chk_u (
    .clk(clk), .reset(reset), .reg_sel(reg_sel), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .acc_valid(acc_valid), .acc_dma(acc_dma), .acc_done(acc_done),
    .acc_fault(acc_fault));
